// ==== core/ubc_top.sv ====
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
// How it works
// [RULE1] control bit selects 16-bit divisor
// [RULE2] 8-bit divisor after reset
// [RULE3] divisor write clears generator timer
// [RULE4] wake enable keeps sampling receive pin
// [RULE5] falling edge raises receive interrupt
// [RULE6] next rising edge clears wake enable
// [RULE7] wake bit zero: idle or done
// [RULE8] auto-baud measures next character
// [RULE9] remote sends 55h sync character
// [RULE10] auto-baud bit self-clears when done
// [RULE11] auto-baud zero: idle or done
// [RULE12] measured count loads divisor pair
module ubc_top
#(
   parameter int CNT_W = 23  // measurement counter width
)
(
   // clock and reset
   input  wire logic       SYS_CLK,
   input  wire logic       RESETN,
   // register port
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] WR_DATA,
   input  wire logic       WR_STB,
   input  wire logic       RD_STB,
   output logic      [7:0] RD_DATA,
   // transceiver side
   input  wire logic       RX_PIN,
   input  wire logic       SYNC_MODE,
   output logic            BAUD_TICK,
   output logic            IRQ
);
   // =============================================
   // parameter check
   // =============================================
   // counter must be wider than the 16-bit divisor, and at most 24 bits
   if (CNT_W < 17 || CNT_W > 24)
      $error("CNT_W must lie between 17 and 24");

   // =============================================
   // declarations
   // =============================================
   typedef enum logic [1:0] {AB_IDLE, AB_SEEK, AB_MEASURE} ubc_abd_t;

   ubc_if u_if ();                        // internal carrier

   logic             wide_q,   wide_d;    // wide_divisor_select
   logic             wake_q,   wake_d;    // rx_wake_enable
   logic             armed_q,  armed_d;   // falling edge seen
   logic             abd_q,    abd_d;     // auto_baud_enable
   logic       [7:0] lo_q,     lo_d;      // divisor_low_byte
   logic       [7:0] hi_q,     hi_d;      // divisor_high_byte
   logic       [1:0] stat_q,   stat_d;    // sticky events
   logic       [1:0] mask_q,   mask_d;    // interrupt mask
   logic             irq_q,    irq_d;     // interrupt output
   logic       [7:0] rd_q,     rd_d;      // read data
   logic             clr_q,    clr_d;     // generator restart
   ubc_abd_t         ab_q,     ab_d;      // measurement state
   logic [CNT_W-1:0] cnt_q,    cnt_d;     // clocks in sync char
   logic       [2:0] falls_q,  falls_d;   // edges counted
   logic             async_m;             // asynchronous mode
   logic             wr_ctrl;             // control write
   logic             wr_lo;
   logic             wr_hi;
   logic      [15:0] meas_div;            // measured divisor
   logic       [1:0] ev;                  // events this cycle

   // compute divisor from clocks per 8 bits
   function automatic logic [15:0] div_of(input logic [CNT_W-1:0] c);
      logic [CNT_W-1:0] q;
      q = c >> ubc_pkg::ABD_SHIFT;
      // a zero result cannot be served; clamp to fastest
      if (q == '0)
         div_of = 16'h0000;
      else
         div_of = 16'(q - 1'b1);
   endfunction

   // =============================================
   // submodules
   // =============================================
   ubc_rx_sample u_sample
   (
      .clk    (SYS_CLK),
      .rst_n  (RESETN),
      .rx_pin (RX_PIN),
      .rx     (u_if.sampler)
   );

   ubc_brg u_brg
   (
      .clk   (SYS_CLK),
      .rst_n (RESETN),
      .bg    (u_if.brg)
   );

   assign u_if.divisor   = {hi_q, lo_q};
   assign u_if.wide      = wide_q;
   assign u_if.brg_clear = clr_q;

   // =============================================
   // decode
   // =============================================
   always_comb
   begin
      async_m  = ~SYNC_MODE;
      wr_ctrl  = WR_STB && (ADDR == ubc_pkg::OFS_CTRL);
      wr_lo    = WR_STB && (ADDR == ubc_pkg::OFS_DIV_LO);
      wr_hi    = WR_STB && (ADDR == ubc_pkg::OFS_DIV_HI);
      meas_div = div_of(cnt_q);
   end

   // =============================================
   // control, wake-up and auto-baud
   // =============================================
   always_comb
   begin
      wide_d  = wide_q;
      wake_d  = wake_q;
      armed_d = armed_q;
      abd_d   = abd_q;
      lo_d    = lo_q;
      hi_d    = hi_q;
      ab_d    = ab_q;
      cnt_d   = cnt_q;
      falls_d = falls_q;
      clr_d   = wr_lo | wr_hi;
      ev      = 2'h0;
      // software writes first; hardware clears below win
      // [RULE1] width select bit
      if (wr_ctrl)
      begin
         wide_d = WR_DATA[ubc_pkg::BIT_WIDE];
         wake_d = WR_DATA[ubc_pkg::BIT_WAKE];
         abd_d  = WR_DATA[ubc_pkg::BIT_ABD];
         if (!WR_DATA[ubc_pkg::BIT_WAKE])
            armed_d = 1'b0;
      end
      if (wr_lo)
         lo_d = WR_DATA;
      if (wr_hi)
         hi_d = WR_DATA;
      // [RULE4] sample pin while wake enabled
      if (wake_q && async_m)
      begin
         // [RULE5] falling edge event
         if (u_if.rx_fall)
         begin
            ev[ubc_pkg::EV_WAKE] = 1'b1;
            armed_d              = 1'b1;
         end
         // [RULE6] self-clear on rising edge
         else if (u_if.rx_rise && armed_q)
         begin
            wake_d  = 1'b0;
            armed_d = 1'b0;
         end
      end
      // a disabled monitor keeps no stale arm for the next enable,
      // else a rising edge could clear wake before any falling edge
      if (!wake_d)
         armed_d = 1'b0;
      // [RULE8] measurement state machine
      unique case (ab_q)
         AB_IDLE:
         begin
            if (abd_q && async_m)
               ab_d = AB_SEEK;
         end
         AB_SEEK:
         begin
            // start bit of the sync character
            if (u_if.rx_fall)
            begin
               ab_d    = AB_MEASURE;
               cnt_d   = '0;
               falls_d = 3'h0;
            end
         end
         AB_MEASURE:
         begin
            // saturate: a stalled line yields the slowest rate
            if (cnt_q != '1)
               cnt_d = cnt_q + 1'b1;
            if (u_if.rx_fall)
            begin
               falls_d = falls_q + 3'h1;
               // [RULE9] fifth falling edge of 55h
               if (falls_q == ubc_pkg::ABD_FALLS - 3'h1)
               begin
                  // [RULE12] load measured divisor
                  lo_d  = meas_div[7:0];
                  hi_d  = meas_div[15:8];
                  clr_d = 1'b1;
                  // [RULE10] self-clear when finished
                  abd_d = 1'b0;
                  ev[ubc_pkg::EV_ABD] = 1'b1;
                  ab_d  = AB_IDLE;
               end
            end
         end
      endcase
      // cancel when software drops the bit or leaves async
      if ((ab_q != AB_IDLE) && (!abd_q || !async_m))
         ab_d = AB_IDLE;
   end

   // registers
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         // [RULE2] narrow divisor after reset
         wide_q  <= ubc_pkg::CTRL_RST[ubc_pkg::BIT_WIDE];
         wake_q  <= ubc_pkg::CTRL_RST[ubc_pkg::BIT_WAKE];
         armed_q <= 1'b0;
         abd_q   <= ubc_pkg::CTRL_RST[ubc_pkg::BIT_ABD];
         lo_q    <= ubc_pkg::DIV_RST;
         hi_q    <= ubc_pkg::DIV_RST;
         ab_q    <= AB_IDLE;
         cnt_q   <= '0;
         falls_q <= 3'h0;
         clr_q   <= 1'b0;
      end
      else
      begin
         wide_q  <= wide_d;
         wake_q  <= wake_d;
         armed_q <= armed_d;
         abd_q   <= abd_d;
         lo_q    <= lo_d;
         hi_q    <= hi_d;
         ab_q    <= ab_d;
         cnt_q   <= cnt_d;
         falls_q <= falls_d;
         clr_q   <= clr_d;
      end
   end

   // =============================================
   // interrupts and read port
   // =============================================
   always_comb
   begin
      // set wins over write-one-to-clear
      stat_d = stat_q;
      if (WR_STB && (ADDR == ubc_pkg::OFS_INT_STAT))
         stat_d = stat_q & ~WR_DATA[1:0];
      stat_d = stat_d | ev;
      mask_d = mask_q;
      if (WR_STB && (ADDR == ubc_pkg::OFS_INT_MASK))
         mask_d = WR_DATA[1:0];
      irq_d  = |(stat_d & mask_d);
      // read data valid only the cycle after the strobe
      rd_d   = 8'h00;
      if (RD_STB)
      begin
         unique case (ADDR)
            // [RULE7] [RULE11] live self-clearing bits
            ubc_pkg::OFS_CTRL:
               rd_d = {1'b0, (ab_q == AB_IDLE) & u_if.rx_level, 2'h0,
                       wide_q, 1'b0, wake_q, abd_q};
            ubc_pkg::OFS_DIV_LO:   rd_d = lo_q;
            ubc_pkg::OFS_DIV_HI:   rd_d = hi_q;
            ubc_pkg::OFS_INT_STAT: rd_d = {6'h00, stat_q};
            ubc_pkg::OFS_INT_MASK: rd_d = {6'h00, mask_q};
            default:               rd_d = 8'h00;
         endcase
      end
   end

   // registers
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         stat_q <= 2'h0;
         mask_q <= ubc_pkg::MASK_RST;
         irq_q  <= 1'b0;
         rd_q   <= 8'h00;
      end
      else
      begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q  <= irq_d;
         rd_q   <= rd_d;
      end
   end

   // tick comes straight from the generator flop
   assign BAUD_TICK = u_if.brg_tick;
   assign IRQ       = irq_q;
   assign RD_DATA   = rd_q;

   // =============================================
   // checks
   // =============================================
   a_div_write_clear : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (wr_lo || wr_hi) |=> clr_q) // [RULE3]
      else $error("divisor write did not restart timer");
   a_wide_follows_bit : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      wr_ctrl |=> (wide_q == $past(WR_DATA[ubc_pkg::BIT_WIDE]))) // [RULE1]
      else $error("width select not stored");
   a_wide_holds : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      !wr_ctrl |=> $stable(wide_q)) // [RULE2]
      else $error("width select changed without a write");
   a_wake_event : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (wake_q && async_m && u_if.rx_fall)
      |=> stat_q[ubc_pkg::EV_WAKE] && (armed_q == wake_q)) // [RULE5]
      else $error("wake edge not flagged");
   a_wake_selfclear : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (wake_q && async_m && armed_q && u_if.rx_rise && !wr_ctrl) |=> !wake_q) // [RULE6]
      else $error("wake enable not cleared on rising edge");
   a_wake_keeps : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (wake_q && !armed_q && !wr_ctrl) |=> wake_q) // [RULE4]
      else $error("wake enable lost before edge");
   a_abd_done : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (ab_q == AB_MEASURE && u_if.rx_fall && falls_q == 3'h3 && !wr_ctrl
       && async_m && abd_q)
      |=> !abd_q && stat_q[ubc_pkg::EV_ABD] && ab_q == AB_IDLE) // [RULE10]
      else $error("auto-baud not finished after fifth edge");
   a_abd_load : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (ab_q == AB_MEASURE && u_if.rx_fall && falls_q == 3'h3 && async_m && abd_q
       && !wr_lo && !wr_hi)
      |=> {hi_q, lo_q} == $past(meas_div)) // [RULE12]
      else $error("measured divisor not loaded");
   a_abd_start : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (ab_q == AB_IDLE && abd_q && async_m) |=> ab_q == AB_SEEK) // [RULE8]
      else $error("measurement did not arm");
   a_irq_level : assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      ##1 IRQ == |(stat_q & mask_q)) // [RULE5]
      else $error("interrupt level mismatch");
endmodule // ubc_top

// ==== core/ubc_pkg.sv ====
// =============================================
// shared constants of the baud control block
// =============================================
package ubc_pkg;
   // register bus widths
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [2:0] OFS_CTRL     = 3'h0;
   localparam logic [2:0] OFS_DIV_LO   = 3'h1;
   localparam logic [2:0] OFS_DIV_HI   = 3'h2;
   localparam logic [2:0] OFS_INT_STAT = 3'h3;
   localparam logic [2:0] OFS_INT_MASK = 3'h4;
   // baud_control field positions
   localparam int BIT_ABD  = 0;
   localparam int BIT_WAKE = 1;
   localparam int BIT_WIDE = 3;
   localparam int BIT_IDLE = 6;
   // interrupt status / mask field positions
   localparam int EV_WAKE = 0;
   localparam int EV_ABD  = 1;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DIV_RST  = 8'h00;
   localparam logic [1:0] MASK_RST = 2'h0;
   // measurement: falling edges after the first one of the sync character
   localparam logic [2:0] ABD_FALLS = 3'h4;
   // 8 bit times at 16 ticks per bit, as a shift
   localparam int ABD_SHIFT = 7;
endpackage

// ==== core/ubc_if.sv ====
`timescale 1ns/10ps
// =============================================
// internal carrier between core, sampler, generator
// =============================================
interface ubc_if;
   logic        rx_level;   // synchronised receive level
   logic        rx_fall;    // one-cycle falling edge
   logic        rx_rise;    // one-cycle rising edge
   logic [15:0] divisor;    // divisor byte pair
   logic        wide;       // 16-bit divisor select
   logic        brg_clear;  // restart generator timer
   logic        brg_tick;   // one-cycle rate pulse
   modport sampler (output rx_level, rx_fall, rx_rise);
   modport brg     (input divisor, wide, brg_clear, output brg_tick);
   modport core    (input rx_level, rx_fall, rx_rise, brg_tick,
                    output divisor, wide, brg_clear);
endinterface // ubc_if

// ==== core/ubc_rx_sample.sv ====
`timescale 1ns/10ps
// =============================================
// receive pin synchroniser and edge finder
// =============================================
module ubc_rx_sample
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin
   input  wire logic rx_pin,
   // toward the core
   ubc_if.sampler    rx
);
   logic sync1_q, sync1_d;  // first stage, read only by second
   logic sync2_q, sync2_d;  // second stage, safe level
   logic prev_q,  prev_d;   // delayed level for edges
   logic fall_q,  fall_d;
   logic rise_q,  rise_d;

   // next values; idle line is high
   always_comb
   begin
      sync1_d = rx_pin;
      sync2_d = sync1_q;
      prev_d  = sync2_q;
      fall_d  = prev_q & ~sync2_q;
      rise_d  = ~prev_q & sync2_q;
   end

   // registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         prev_q  <= 1'b1;
         fall_q  <= 1'b0;
         rise_q  <= 1'b0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q  <= prev_d;
         fall_q  <= fall_d;
         rise_q  <= rise_d;
      end
   end

   assign rx.rx_level = prev_q;
   assign rx.rx_fall  = fall_q;
   assign rx.rx_rise  = rise_q;
endmodule // ubc_rx_sample

// ==== core/ubc_brg.sv ====
`timescale 1ns/10ps
// =============================================
// free running baud generator timer
// =============================================
module ubc_brg
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control from the core
   ubc_if.brg        bg
);
   logic [15:0] cnt_q, cnt_d;   // timer
   logic        tick_q, tick_d; // rate pulse
   logic [15:0] term;           // terminal count

   // [RULE1] width select
   // low byte alone unless wide is set
   always_comb
   begin
      term = bg.wide ? bg.divisor : {8'h00, bg.divisor[7:0]};
   end

   // next timer value
   always_comb
   begin
      cnt_d  = cnt_q + 16'h0001;
      tick_d = 1'b0;
      // [RULE3] restart on divisor write
      if (bg.brg_clear)
      begin
         cnt_d = 16'h0000;
      end
      // period is divisor plus one
      else if (cnt_q >= term)
      begin
         cnt_d  = 16'h0000;
         tick_d = 1'b1;
      end
   end

   // registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign bg.brg_tick = tick_q;

   // [RULE3] timer cleared by a write
   a_brg_clear_zero : assert property (@(posedge clk) disable iff (!rst_n)
      bg.brg_clear |=> (cnt_q == 16'h0000) && !tick_q) // [RULE3]
      else $error("generator timer not cleared");
   // [RULE1] narrow mode ignores high byte
   a_brg_narrow_term : assert property (@(posedge clk) disable iff (!rst_n)
      !bg.wide |-> (cnt_q <= {8'h00, bg.divisor[7:0]}) || $changed(bg.divisor)
      || $changed(bg.wide)) // [RULE1]
      else $error("narrow timer ran past low byte");
endmodule // ubc_brg

// ==== tb/ubc_rx_partner.sv ====
`timescale 1ns/10ps
// =============================================
// remote serial transmitter on the receive pin
// =============================================
module ubc_rx_partner
(
   // clock
   input  wire logic clk,
   // line toward the device
   output logic      rx_pin
);
   // a stopped 8N1 link idles high
   initial rx_pin = 1'b1;

   // hold the line at one level for a number of clocks
   task automatic hold_line(input logic lvl, input int clks);
      rx_pin <= lvl;
      repeat (clks) @(posedge clk);
   endtask

   // one 8N1 frame, lsb first; bit_clks sets the rate
   // sends start bit, the eight data bits and stop bit
   task automatic send_frame(input logic [7:0] data, input int bit_clks);
      @(posedge clk);
      hold_line(1'b0, bit_clks);
      for (int i = 0; i < 8; i++)
      begin
         hold_line(data[i], bit_clks);
      end
      // stop bit leaves the line high
      hold_line(1'b1, bit_clks);
   endtask
endmodule // ubc_rx_partner

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
// =============================================
// compare helper, counts every check
// =============================================
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("[ERR] %0t got %0h expected %0h", $time, (got), (exp)); \
      end \
   end

module tb_top;
   // =============================================
   // bench signals
   // =============================================
   logic       sys_clk;      // 40 MHz system clock
   logic       resetn;       // active low reset
   logic [2:0] addr;         // register offset
   logic [7:0] wr_data;      // write data
   logic       wr_stb;       // write strobe
   logic       rd_stb;       // read strobe
   logic [7:0] rd_data;      // read data
   logic       rx_pin;       // receive line from partner
   logic       sync_mode;    // synchronous mode select
   logic       baud_tick;    // rate pulse
   logic       irq;          // interrupt level
   int         errors;       // mismatches
   int         checks_done;  // comparisons made
   logic [7:0] v;            // last read value
   int         n;            // measured cycle count

   // =============================================
   // clock, design and partner
   // =============================================
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   ubc_top #(.CNT_W(23)) dut_u
   (
      .SYS_CLK   (sys_clk),
      .RESETN    (resetn),
      .ADDR      (addr),
      .WR_DATA   (wr_data),
      .WR_STB    (wr_stb),
      .RD_STB    (rd_stb),
      .RD_DATA   (rd_data),
      .RX_PIN    (rx_pin),
      .SYNC_MODE (sync_mode),
      .BAUD_TICK (baud_tick),
      .IRQ       (irq)
   );

   ubc_rx_partner partner_u
   (
      .clk    (sys_clk),
      .rx_pin (rx_pin)
   );

   // =============================================
   // register port tasks
   // =============================================
   // one-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge sys_clk);
      wr_stb  <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask

   // clocks between two ticks; bounded so a dead timer cannot hang
   task automatic period(output int cnt);
      int k;
      k   = 0;
      cnt = 0;
      // let a pending restart settle; a stale tick is no start point
      repeat (2) @(posedge sys_clk);
      #1;
      while (baud_tick !== 1'b1 && k < 70000)
      begin
         @(posedge sys_clk);
         #1 k++;
      end
      do
      begin
         @(posedge sys_clk);
         #1 cnt++;
      end
      while (baud_tick !== 1'b1 && cnt < 70000);
   endtask

   // verdict, reached from the sequence or the watchdog
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // =============================================
   // watchdog, well beyond the ~2k cycles of the run
   // =============================================
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end

   // =============================================
   // main sequence
   // =============================================
   initial
   begin
      errors      = 0;
      checks_done = 0;
      resetn      = 1'b0;
      addr        = 3'h0;
      wr_data     = 8'h00;
      wr_stb      = 1'b0;
      rd_stb      = 1'b0;
      sync_mode   = 1'b0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      // reset values; idle bit high with the line high
      rd(ubc_pkg::OFS_CTRL, v); `CHK(v, 8'h40);
      // offset 5 is unmapped, its write must vanish
      wr(3'h5, 8'hFF);
      for (int a = 1; a < 6; a++)
      begin
         rd(3'(a), v); `CHK(v, 8'h00);
      end
      // narrow mode ignores the high byte
      wr(ubc_pkg::OFS_DIV_HI, 8'h01);
      wr(ubc_pkg::OFS_DIV_LO, 8'h04);
      period(n); `CHK(n, 5);
      // read-only and unused bits stay put
      wr(ubc_pkg::OFS_CTRL, 8'hF8);
      rd(ubc_pkg::OFS_CTRL, v); `CHK(v, 8'h48);
      period(n); `CHK(n, 261);
      // huge divisor, then shrink it: the old count must not linger
      wr(ubc_pkg::OFS_DIV_HI, 8'hFF);
      repeat (20) @(posedge sys_clk);
      wr(ubc_pkg::OFS_DIV_HI, 8'h00);
      n = 0;
      while (baud_tick !== 1'b1 && n < 20)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      // one restart cycle, then a full period of divisor 4;
      // a lingering count would tick at once
      `CHK(n, 6);
      // wake with the event masked
      wr(ubc_pkg::OFS_CTRL, 8'h02);
      partner_u.hold_line(1'b0, 10);
      rd(ubc_pkg::OFS_INT_STAT, v); `CHK(v, 8'h01);
      `CHK(irq, 1'b0);
      rd(ubc_pkg::OFS_CTRL, v); `CHK(v, 8'h02);
      partner_u.hold_line(1'b1, 10);
      rd(ubc_pkg::OFS_CTRL, v); `CHK(v, 8'h40);
      // unmask, then clear by writing one
      wr(ubc_pkg::OFS_INT_MASK, 8'h01);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b1);
      wr(ubc_pkg::OFS_INT_STAT, 8'h01);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b0);
      // disarmed: a new edge is no event
      partner_u.hold_line(1'b0, 10);
      partner_u.hold_line(1'b1, 10);
      rd(ubc_pkg::OFS_INT_STAT, v); `CHK(v, 8'h00);
      // synchronous mode ignores wake and auto-baud
      sync_mode <= 1'b1;
      wr(ubc_pkg::OFS_CTRL, 8'h03);
      partner_u.send_frame(8'h55, 72);
      rd(ubc_pkg::OFS_INT_STAT, v); `CHK(v, 8'h00);
      rd(ubc_pkg::OFS_DIV_LO, v); `CHK(v, 8'h04);
      wr(ubc_pkg::OFS_CTRL, 8'h00);
      sync_mode <= 1'b0;
      // auto-baud at 72 clocks a bit: count 575, divisor 3
      wr(ubc_pkg::OFS_INT_MASK, 8'h02);
      wr(ubc_pkg::OFS_DIV_HI, 8'h5A);
      wr(ubc_pkg::OFS_CTRL, 8'h01);
      rd(ubc_pkg::OFS_CTRL, v); `CHK(v & 8'hBF, 8'h01);
      partner_u.send_frame(8'h55, 72);
      repeat (10) @(posedge sys_clk);
      `CHK(irq, 1'b1);
      rd(ubc_pkg::OFS_CTRL, v); `CHK(v & 8'hBF, 8'h00);
      rd(ubc_pkg::OFS_INT_STAT, v); `CHK(v, 8'h02);
      rd(ubc_pkg::OFS_DIV_LO, v); `CHK(v, 8'h03);
      rd(ubc_pkg::OFS_DIV_HI, v); `CHK(v, 8'h00);
      period(n); `CHK(n, 4);
      close_out();
   end
endmodule // tb_top
